/* isf_top.sv */
// interrupt status flag register with read-to-clear and interrupt pin
`timescale 1ns/100ps
module isf_top (
  input wire logic clock,
  input wire logic srst,
  input wire isf_pkg::isf_events_t events,
  input wire isf_pkg::isf_mode_t mode,
  input wire logic per_cycle_irq_enable,
  input wire logic irq_enable,
  input wire logic case_switch_pin,
  input wire logic read_strobe,
  input wire logic [7:0] read_opcode,
  output logic [15:0] interrupt_flags,
  output logic irq_n,
  output logic spi_available
);
  logic [15:0] flags_reg;
  logic [15:0] set_vec;
  logic status_read;
  logic irq_pending_reg;
  logic powered_reg;
  logic in_flight_seq;
  logic in_thermal_seq;

  assign status_read = read_strobe && (read_opcode == isf_pkg::ISF_READ_OPCODE);
  assign in_flight_seq = mode.sequence_both_cmd || mode.sequence_flight_cmd;
  assign in_thermal_seq = mode.sequence_both_cmd || mode.sequence_thermal_cmd;

  always_comb
  begin
    set_vec = 16'h0000;
    set_vec[isf_pkg::ISF_DEADLINE_BIT] = events.deadline_miss;
    set_vec[isf_pkg::ISF_ALARM_BIT] = events.alarm_match;
    set_vec[isf_pkg::ISF_FLIGHT_BIT] = events.flight_cmd_done
      || (events.flight_cycle_done && in_flight_seq && per_cycle_irq_enable);
    set_vec[isf_pkg::ISF_THERMAL_BIT] = events.thermal_cmd_done
      || (events.thermal_cycle_done && in_thermal_seq && per_cycle_irq_enable);
    set_vec[isf_pkg::ISF_REGULATOR_BIT] = events.regulator_stable;
    set_vec[isf_pkg::ISF_SEQ_FLIGHT_BIT] = events.seq_flight_last && in_flight_seq;
    set_vec[isf_pkg::ISF_SEQ_THERMAL_BIT] = events.seq_thermal_last && in_thermal_seq;
    set_vec[isf_pkg::ISF_FLASH_BIT] = events.flash_write_done;
    set_vec[isf_pkg::ISF_CAL_BIT] = events.cal_done && events.cal_by_host;
    set_vec[isf_pkg::ISF_HALT_BIT] = events.halt_done;
    set_vec[isf_pkg::ISF_TAMPER_BIT] = case_switch_pin;
    set_vec[isf_pkg::ISF_INIT_BIT] = events.init_done;
    set_vec[isf_pkg::ISF_POWER_BIT] = events.power_up_done && !powered_reg;
    set_vec = set_vec & isf_pkg::ISF_IMPLEMENTED_MASK;
  end

  // set wins over the read-clear
  always_ff @(posedge clock)
  begin
    if (srst)
      flags_reg <= isf_pkg::ISF_RESET_VALUE;
    else if (status_read)
      flags_reg <= set_vec;
    else
      flags_reg <= flags_reg | set_vec;
  end

  // pin latched on any flag set while irq_enable is high, released only by a status read
  always_ff @(posedge clock)
  begin
    if (srst)
      irq_pending_reg <= 1'b0;
    else if (irq_enable && (set_vec != 16'h0000))
      irq_pending_reg <= 1'b1;
    else if (status_read)
      irq_pending_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      powered_reg <= 1'b0;
    else if (events.power_up_done)
      powered_reg <= 1'b1;
  end

  assign interrupt_flags = flags_reg;
  assign irq_n = !irq_pending_reg;
  assign spi_available = powered_reg && !mode.flash_write_busy;

  // register access: read decode and read-clear
  clear_on_read_a: assert property (
    @(posedge clock) disable iff (srst)
    status_read && set_vec == 16'h0000
    |=> flags_reg == 16'h0000)
    else $error("flags not cleared by read");

  other_opcode_a: assert property (
    @(posedge clock) disable iff (srst)
    read_strobe && read_opcode != isf_pkg::ISF_READ_OPCODE && set_vec == 16'h0000
    |=> $stable(flags_reg))
    else $error("flags changed by foreign opcode");

  // completion and timeout events reach their flag one cycle later
  deadline_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.deadline_miss
    |=> flags_reg[15])
    else $error("deadline flag missing");

  alarm_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.alarm_match
    |=> flags_reg[14])
    else $error("alarm flag missing");

  flight_cmd_a: assert property (
    @(posedge clock) disable iff (srst)
    events.flight_cmd_done
    |=> flags_reg[isf_pkg::ISF_FLIGHT_BIT])
    else $error("flight command flag missing");

  flight_cycle_a: assert property (
    @(posedge clock) disable iff (srst)
    events.flight_cycle_done && mode.sequence_flight_cmd && per_cycle_irq_enable
    |=> flags_reg[12])
    else $error("per-cycle flight flag missing");

  flight_quiet_a: assert property (
    @(posedge clock) disable iff (srst)
    events.flight_cycle_done && !per_cycle_irq_enable && !events.flight_cmd_done && !flags_reg[12]
    |=> !flags_reg[12])
    else $error("flight flag set without enable");

  thermal_cmd_a: assert property (
    @(posedge clock) disable iff (srst)
    events.thermal_cmd_done
    |=> flags_reg[isf_pkg::ISF_THERMAL_BIT])
    else $error("thermal command flag missing");

  thermal_seq_a: assert property (
    @(posedge clock) disable iff (srst)
    events.thermal_cycle_done && mode.sequence_thermal_cmd && per_cycle_irq_enable
    |=> flags_reg[11])
    else $error("per-cycle thermal flag missing");

  thermal_cycle_a: assert property (
    @(posedge clock) disable iff (srst)
    events.thermal_cycle_done && !per_cycle_irq_enable && !events.thermal_cmd_done && !flags_reg[11]
    |=> !flags_reg[11])
    else $error("thermal flag set without enable");

  regulator_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.regulator_stable
    |=> flags_reg[isf_pkg::ISF_REGULATOR_BIT])
    else $error("regulator flag missing");

  // sequence results only while the matching sequence runs
  seq_flight_a: assert property (
    @(posedge clock) disable iff (srst)
    events.seq_flight_last && mode.sequence_flight_cmd
    |=> flags_reg[isf_pkg::ISF_SEQ_FLIGHT_BIT])
    else $error("flight sequence flag missing");

  seq_flight_idle_a: assert property (
    @(posedge clock) disable iff (srst)
    events.seq_flight_last && !in_flight_seq && !flags_reg[9]
    |=> !flags_reg[9])
    else $error("flight sequence flag outside sequence");

  seq_thermal_a: assert property (
    @(posedge clock) disable iff (srst)
    events.seq_thermal_last && mode.sequence_thermal_cmd
    |=> flags_reg[isf_pkg::ISF_SEQ_THERMAL_BIT])
    else $error("thermal sequence flag missing");

  seq_thermal_idle_a: assert property (
    @(posedge clock) disable iff (srst)
    events.seq_thermal_last && !in_thermal_seq && !flags_reg[8]
    |=> !flags_reg[8])
    else $error("thermal sequence flag outside sequence");

  // flash writes lock the serial port until done
  flash_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.flash_write_done
    |=> flags_reg[isf_pkg::ISF_FLASH_BIT])
    else $error("flash flag missing");

  flash_spi_a: assert property (
    @(posedge clock) disable iff (srst)
    mode.flash_write_busy
    |-> !spi_available)
    else $error("spi open during flash write");

  spi_back_a: assert property (
    @(posedge clock) disable iff (srst)
    powered_reg && !mode.flash_write_busy
    |-> spi_available)
    else $error("spi not reopened");

  cal_host_a: assert property (
    @(posedge clock) disable iff (srst)
    events.cal_done && events.cal_by_host
    |=> flags_reg[isf_pkg::ISF_CAL_BIT])
    else $error("host calibration flag missing");

  cal_auto_a: assert property (
    @(posedge clock) disable iff (srst)
    events.cal_done && !events.cal_by_host && !flags_reg[6]
    |=> !flags_reg[6])
    else $error("automatic calibration set flag");

  halt_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.halt_done
    |=> flags_reg[isf_pkg::ISF_HALT_BIT])
    else $error("halt flag missing");

  tamper_set_a: assert property (
    @(posedge clock) disable iff (srst)
    case_switch_pin
    |=> flags_reg[4])
    else $error("tamper flag missing");

  init_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.init_done
    |=> flags_reg[isf_pkg::ISF_INIT_BIT])
    else $error("initialize flag missing");

  // power-up flag only once, port closed before it
  power_set_a: assert property (
    @(posedge clock) disable iff (srst)
    events.power_up_done && !powered_reg
    |=> flags_reg[isf_pkg::ISF_POWER_BIT] && spi_available == !mode.flash_write_busy)
    else $error("power-up flag missing");

  power_once_a: assert property (
    @(posedge clock) disable iff (srst)
    powered_reg && !flags_reg[2]
    |=> !flags_reg[2])
    else $error("power-up flag set twice");

  spi_locked_a: assert property (
    @(posedge clock) disable iff (srst)
    !powered_reg
    |-> !spi_available)
    else $error("spi open before power-up");

  // interrupt pin
  irq_raise_a: assert property (
    @(posedge clock) disable iff (srst)
    irq_enable && set_vec != 16'h0000
    |=> !irq_n)
    else $error("interrupt not raised");

  irq_hold_a: assert property (
    @(posedge clock) disable iff (srst)
    !irq_n && !status_read
    |=> !irq_n)
    else $error("interrupt dropped without read");

  irq_release_a: assert property (
    @(posedge clock) disable iff (srst)
    status_read && (!irq_enable || set_vec == 16'h0000)
    |=> irq_n)
    else $error("interrupt not released by read");

  reserved_zero_a: assert property (
    @(posedge clock) disable iff (srst)
    1'b1
    |-> (flags_reg & ~isf_pkg::ISF_IMPLEMENTED_MASK) == 16'h0000)
    else $error("reserved bit set");

  // each flag stands until a read; a set in the read cycle wins
  for (genvar i = 0; i < 16; i++)
  begin : g_flag_check
    if (isf_pkg::ISF_IMPLEMENTED_MASK[i])
    begin : g_impl
      flag_hold_a: assert property (
        @(posedge clock) disable iff (srst)
        flags_reg[i] && !status_read
        |=> flags_reg[i])
        else $error("flag dropped without read");

      set_wins_a: assert property (
        @(posedge clock) disable iff (srst)
        status_read && set_vec[i]
        |=> flags_reg[i])
        else $error("flag lost when set during read");
    end
  end

  // main scenarios
  read_clear_c: cover property (
    @(posedge clock) disable iff (srst)
    !irq_n ##1 status_read ##1 irq_n);

  set_on_read_c: cover property (
    @(posedge clock) disable iff (srst)
    status_read && set_vec != 16'h0000);

  power_up_c: cover property (
    @(posedge clock) disable iff (srst)
    events.power_up_done ##1 spi_available);

  flash_done_c: cover property (
    @(posedge clock) disable iff (srst)
    events.flash_write_done ##1 spi_available);

  seq_cycle_c: cover property (
    @(posedge clock) disable iff (srst)
    events.flight_cycle_done && mode.sequence_flight_cmd && per_cycle_irq_enable);
endmodule : isf_top

/* isf_pkg.sv */
// constants and carrier types for the interrupt status flag block
package isf_pkg;
  localparam logic [7:0] ISF_READ_OPCODE = 8'hfe;
  localparam logic [15:0] ISF_RESET_VALUE = 16'h0000;
  localparam int ISF_DEADLINE_BIT = 15;
  localparam int ISF_ALARM_BIT = 14;
  localparam int ISF_FLIGHT_BIT = 12;
  localparam int ISF_THERMAL_BIT = 11;
  localparam int ISF_REGULATOR_BIT = 10;
  localparam int ISF_SEQ_FLIGHT_BIT = 9;
  localparam int ISF_SEQ_THERMAL_BIT = 8;
  localparam int ISF_FLASH_BIT = 7;
  localparam int ISF_CAL_BIT = 6;
  localparam int ISF_HALT_BIT = 5;
  localparam int ISF_TAMPER_BIT = 4;
  localparam int ISF_INIT_BIT = 3;
  localparam int ISF_POWER_BIT = 2;
  localparam logic [15:0] ISF_IMPLEMENTED_MASK = 16'hdffc;

  // one-cycle completion pulses from the measurement and command logic
  typedef struct packed {
    logic deadline_miss;
    logic alarm_match;
    logic flight_cmd_done;
    logic flight_cycle_done;
    logic thermal_cmd_done;
    logic thermal_cycle_done;
    logic regulator_stable;
    logic seq_flight_last;
    logic seq_thermal_last;
    logic flash_write_done;
    logic cal_done;
    logic cal_by_host;
    logic halt_done;
    logic init_done;
    logic power_up_done;
  } isf_events_t;

  // which command is running
  typedef struct packed {
    logic sequence_both_cmd;
    logic sequence_flight_cmd;
    logic sequence_thermal_cmd;
    logic flash_write_busy;
  } isf_mode_t;
endpackage : isf_pkg

/* isf_host.sv */
// host model that reads the flag register over its read strobe
`timescale 1ns/100ps
module isf_host (
  input wire logic clock,
  input wire logic spi_available,
  input wire logic [15:0] interrupt_flags,
  output logic read_strobe,
  output logic [7:0] read_opcode
);
  initial read_strobe = 1'b0;
  initial read_opcode = 8'h00;
  task automatic rd(input logic [7:0] op, output logic [15:0] val);
    int n = 0;
    while (spi_available !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    #1 read_strobe = 1'b1;
    read_opcode = op;
    @(negedge clock);
    val = interrupt_flags;
    @(posedge clock);
    #1 read_strobe = 1'b0;
    read_opcode = ~op;
  endtask : rd
endmodule : isf_host

/* isf_bench.sv */
// bench for the interrupt status flag register
`timescale 1ns/100ps
module interrupt_status_flags_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  isf_pkg::isf_events_t events = '0;
  isf_pkg::isf_mode_t mode = '0;
  logic per_cycle_irq_enable = 1'b1;
  logic irq_enable = 1'b1;
  logic case_switch_pin = 1'b0;
  logic read_strobe;
  logic [7:0] read_opcode;
  logic [15:0] interrupt_flags;
  logic irq_n;
  logic spi_available;
  logic [15:0] v;
  int failures = 0;
  int total_checks = 0;
  // event pulse and expected word, sequence mode active
  logic [30:0] tbl [12] = '{{15'h4000, 16'h8000}, {15'h2000, 16'h4000},
    {15'h1000, 16'h1000}, {15'h0800, 16'h1000}, {15'h0400, 16'h0800},
    {15'h0200, 16'h0800}, {15'h0100, 16'h0400}, {15'h0080, 16'h0200},
    {15'h0040, 16'h0100}, {15'h0018, 16'h0040}, {15'h0010, 16'h0000},
    {15'h0002, 16'h0008}};
  always #2.5 clock = ~clock;
  isf_top isf_top_inst (.clock, .srst, .events, .mode, .per_cycle_irq_enable, .irq_enable,
    .case_switch_pin, .read_strobe, .read_opcode, .interrupt_flags, .irq_n, .spi_available);
  isf_host isf_host_inst (.clock, .spi_available, .interrupt_flags, .read_strobe, .read_opcode);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [14:0] e);
    @(posedge clock);
    #1 events = e;
    @(posedge clock);
    #1 events = '0;
  endtask : pulse
  task automatic one_event(input logic [14:0] e, input logic [15:0] exp);
    pulse(e);
    chk(interrupt_flags, exp);
    chk({15'h0, irq_n}, {15'h0, exp == 16'h0000});
    isf_host_inst.rd(8'hfe, v);
    chk(v, exp);
    chk(interrupt_flags, 16'h0000);
    chk({15'h0, irq_n}, 16'h0001);
  endtask : one_event
  task automatic results();
    $display("failures %0d, checks %0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (2) @(posedge clock);
    #1 srst = 1'b0;
    chk(interrupt_flags, isf_pkg::ISF_RESET_VALUE);
    chk({15'h0, spi_available}, 16'h0000);
    one_event(15'h0001, 16'h0004);
    chk({15'h0, spi_available}, 16'h0001);
    one_event(15'h0001, 16'h0000);
    mode = 4'b1000;
    foreach (tbl[i])
      one_event(tbl[i][30:16], tbl[i][15:0]);
    pulse(15'h0004);
    isf_host_inst.rd(8'h7f, v);
    chk(interrupt_flags, 16'h0020);
    one_event(15'h0004, 16'h0020);
    mode = 4'b1001;
    @(posedge clock);
    #1 chk({15'h0, spi_available}, 16'h0000);
    mode = 4'b1000;
    one_event(15'h0020, 16'h0080);
    case_switch_pin = 1'b1;
    @(posedge clock);
    #1 case_switch_pin = 1'b0;
    one_event(15'h0000, 16'h0010);
    per_cycle_irq_enable = 1'b0;
    one_event(15'h0800, 16'h0000);
    one_event(15'h0200, 16'h0000);
    per_cycle_irq_enable = 1'b1;
    mode = 4'b0100;
    one_event(15'h0800, 16'h1000);
    one_event(15'h0080, 16'h0200);
    one_event(15'h0040, 16'h0000);
    mode = 4'b0010;
    one_event(15'h0200, 16'h0800);
    one_event(15'h0040, 16'h0100);
    one_event(15'h0080, 16'h0000);
    mode = 4'b0000;
    one_event(15'h0080, 16'h0000);
    irq_enable = 1'b0;
    pulse(15'h0004);
    chk({15'h0, irq_n}, 16'h0001);
    results();
  end
  initial
  begin
    #20000;
    failures++;
    results();
  end
endmodule : interrupt_status_flags_bench
